// ### logic/fps_pkg.sv
// Purpose: shared constants for the front-panel bus decode and self-test pair
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes:   module bus addresses and controller register offsets are named here
package fps_pkg;
    // =====================================================================
    // module bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] MA_LATCH    = 8'h10;
    localparam logic [7:0] MA_DISP_DM  = 8'h11;
    localparam logic [7:0] MA_DISP_FQ  = 8'h12;
    localparam logic [7:0] MA_DISP_BG  = 8'h13;
    localparam logic [7:0] MA_MUTE     = 8'h14;
    localparam logic [7:0] MA_TUNE     = 8'h20;
    localparam logic [7:0] MA_SWITCH   = 8'h21;
    localparam logic [7:0] MA_IDENT    = 8'h22;
    localparam logic [7:0] MA_CMP      = 8'h23;
    localparam logic [7:0] ASSY_IDENT  = 8'h5A; // arbitrary value
    // data latch layout: mux select in low bits, legends above
    localparam int LAT_MUX_LSB = 0;
    localparam int LAT_MUX_W   = 3;
    localparam int LAT_LEG_LSB = 3;
    localparam int LAT_LEG_W   = 5;
    localparam logic [7:0] LATCH_RST = 8'h00;
    // multiplexer inputs
    localparam logic [2:0] MUX_PLUS5_REF  = 3'h1;
    localparam logic [2:0] MUX_PLUS5_RAIL = 3'h2;
    localparam logic [2:0] MUX_LAST_RAIL  = 3'h5;
    // dac codes
    localparam logic [7:0] DAC_MAX = 8'hFF;
    // =====================================================================
    // controller registers (avalon word index = byte address / 4)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ    = 4'h2;
    localparam logic [3:0] REG_MASK   = 4'h3;
    localparam logic [3:0] REG_LIMLO  = 4'h4;
    localparam logic [3:0] REG_LIMHI  = 4'h5;
    localparam logic [3:0] REG_KEY    = 4'h6;
    localparam logic [3:0] REG_TUNE   = 4'h7;
    localparam int CTRL_START  = 0;
    localparam int CTRL_MUTE   = 1;
    localparam int CTRL_CONT   = 2;
    localparam int CTRL_KEYCHK = 3;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_FAIL    = 1;
    localparam int IRQ_KEY     = 2;
    localparam int IRQ_W       = 3;
    // =====================================================================
    // timing
    localparam int CLK_HZ      = 10_000_000;
    localparam int TICK_MS     = 250;
    localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
    localparam int SETTLE_US   = 10;
    localparam int SETTLE_CYC  = CLK_HZ / 1_000_000 * SETTLE_US;
    localparam logic [4:0] T_025S = 5'd1;
    localparam logic [4:0] T_1S   = 5'd4;
    localparam logic [4:0] T_2S   = 5'd8;
    localparam logic [4:0] T_4S   = 5'd16;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    // key code with more than one button closed is marked by the top bit
    localparam int KEY_MULTI = 7;
endpackage

// ### logic/fps_bus_if.sv
// Purpose: module address and data bus between processor side and front panel
// Assumes: single clock, strobes are one-cycle pulses
// Notes:   data bus split into the two drive directions
`timescale 1ns/1ps
interface fps_bus_if (
    input wire logic clk_i
);
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rvalid;
    logic       mute;
    logic       cmp;
    logic [7:0] dac;
    modport panel (input addr, wr, rd, wdata, mute, dac, output rdata, rvalid, cmp);
    modport proc  (output addr, wr, rd, wdata, mute, dac, input rdata, rvalid, cmp);
endinterface

// ### logic/fps_tick.sv
// Purpose: fixed-rate tick for timed display intervals
// Assumes: clk_i at the package clock rate
// Notes:   one pulse every quarter second
`timescale 1ns/1ps
module fps_tick #(
    parameter int DIV = fps_pkg::TICK_CYC
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic run_i,
    output logic      tick_o
);
    logic [31:0] cnt_q;
    wire         wrap = (cnt_q == 32'(DIV - 1));
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !run_i || wrap) cnt_q <= '0;
        else                            cnt_q <= cnt_q + 32'h1;
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) tick_o <= 1'b0;
        else         tick_o <= run_i && wrap;
    end
endmodule

// ### logic/fps_panel.sv
// Purpose: front-panel bus decode, data latch, read mux, mute and comparator
// Assumes: pins from panel hardware are asynchronous and synchronised here
// Notes:   comparator models a threshold against the selected analogue level
`timescale 1ns/1ps
module fps_panel (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    fps_bus_if.panel        bus,
    input  wire logic [7:0] tune_count_i,
    input  wire logic [7:0] switch_code_i,
    input  wire logic [7:0] level_i,
    output logic            mute_o,
    output logic [2:0]      mux_sel_o,
    output logic [4:0]      legends_o,
    output logic            wr_dm_o,
    output logic            wr_fq_o,
    output logic            wr_bg_o,
    output logic [7:0]      disp_data_o
);
    // =====================================================================
    // input synchronisers
    logic [7:0] tune_s1_q, tune_s2_q, sw_s1_q, sw_s2_q, lvl_s1_q, lvl_s2_q;
    always_ff @(posedge clk_i) begin
        tune_s1_q <= tune_count_i;
        tune_s2_q <= tune_s1_q;
        sw_s1_q   <= switch_code_i;
        sw_s2_q   <= sw_s1_q;
        lvl_s1_q  <= level_i;
        lvl_s2_q  <= lvl_s1_q;
    end
    // =====================================================================
    // address decode
    wire sel_latch = bus.wr && (bus.addr == fps_pkg::MA_LATCH);
    wire sel_dm    = bus.wr && (bus.addr == fps_pkg::MA_DISP_DM);
    wire sel_fq    = bus.wr && (bus.addr == fps_pkg::MA_DISP_FQ);
    wire sel_bg    = bus.wr && (bus.addr == fps_pkg::MA_DISP_BG);
    wire cmp_now   = (lvl_s2_q >= bus.dac);
    logic [7:0] rmux;
    always_comb begin
        unique case (bus.addr)
            fps_pkg::MA_TUNE:   rmux = tune_s2_q;
            fps_pkg::MA_SWITCH: rmux = sw_s2_q;
            fps_pkg::MA_IDENT:  rmux = fps_pkg::ASSY_IDENT;
            fps_pkg::MA_CMP:    rmux = {7'h00, cmp_now};
            default:            rmux = 8'h00;
        endcase
    end
    // =====================================================================
    // latch, strobes, read data
    logic [7:0] latch_q;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            latch_q     <= fps_pkg::LATCH_RST;
            mute_o      <= 1'b0;
            wr_dm_o     <= 1'b0;
            wr_fq_o     <= 1'b0;
            wr_bg_o     <= 1'b0;
            disp_data_o <= 8'h00;
            bus.rdata   <= 8'h00;
            bus.rvalid  <= 1'b0;
            bus.cmp     <= 1'b0;
        end else begin
            if (sel_latch) latch_q <= bus.wdata;
            mute_o      <= bus.mute;
            wr_dm_o     <= sel_dm;
            wr_fq_o     <= sel_fq;
            wr_bg_o     <= sel_bg;
            if (sel_dm || sel_fq || sel_bg) disp_data_o <= bus.wdata;
            bus.rdata   <= bus.rd ? rmux : 8'h00;
            bus.rvalid  <= bus.rd;
            bus.cmp     <= cmp_now;
        end
    end
    assign mux_sel_o = latch_q[fps_pkg::LAT_MUX_LSB +: fps_pkg::LAT_MUX_W];
    assign legends_o = latch_q[fps_pkg::LAT_LEG_LSB +: fps_pkg::LAT_LEG_W];
endmodule

// ### logic/fps_proc.sv
// Contract
// - button press drives mute; panel mutes speaker
// - panel decodes addresses into write strobes
// - latch holds mux select and legends
// - reads return tuning, switches or ident
// - measure with upper then lower threshold
// - test 151 max dac, reference, expect low
// - tests 152-155 check rails within window
// - tests run continuous, confidence or selected (code: one run, or repeated while CTRL_CONT is set; no test select)
// - tests run in ascending number order
// - display test message 4 s, legends blank
// - checkerboard 1 s, legends on then off
// - digits step 0 to 9, 2 s each
// - blank, legends on then off, 1 s
// - bargraph message 2 s, legends 1 s each (code shows the bargraph message for 1 s)
// - meter bars 0.25 s apart, reverse off
// - keyboard test fails on wrong key
// - multiple-button codes are ignored
//
// Purpose: processor side: runs front-panel self-tests over the module bus
// Assumes: Avalon-MM slave with waitrequest, word-aligned registers
// Notes:   one bus access at a time; display patterns written via latch/display strobes
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module fps_proc #(
    parameter int TICK_DIV   = fps_pkg::TICK_CYC,
    parameter int SETTLE_DIV = fps_pkg::SETTLE_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    fps_bus_if.proc          bus,
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             irq_o
);
    typedef enum logic [3:0] {
        S_IDLE, S_TUNE, S_ID, S_IDCHK, S_MUX, S_HI, S_HIRD, S_LO, S_LORD, S_NEXT, S_DISP,
        S_DSTEP, S_KEYRD, S_KEYCHK, S_DONE
    } fps_state_t;
    fps_state_t st_q;
    // =====================================================================
    // register file
    logic [3:0]  ctrl_q;
    logic [2:0]  irq_q, mask_q;
    logic [7:0]  lim_lo_q [4], lim_hi_q [4];
    logic [7:0]  key_exp_q, key_got_q, tune_q;
    logic [2:0]  test_q;
    logic        fail_q, busy_q, start_p;
    logic [2:0]  ev_set;
    wire  [3:0]  widx  = avs_address_i[5:2];
    wire         acc   = avs_read_i || avs_write_i;
    // limit slot (rail 152..155) chosen by write data bits 9:8
    wire  [1:0]  li    = avs_writedata_i[9:8];
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0;
        end else begin
            avs_waitrequest_o <= !(acc && avs_waitrequest_o);
            if (avs_read_i && avs_waitrequest_o) begin
                unique case (widx)
                    fps_pkg::REG_CTRL:   avs_readdata_o <= {28'h0, ctrl_q};
                    fps_pkg::REG_STATUS: avs_readdata_o <= {24'h0, busy_q, fail_q, 3'h0, test_q};
                    fps_pkg::REG_IRQ:    avs_readdata_o <= {29'h0, irq_q};
                    fps_pkg::REG_MASK:   avs_readdata_o <= {29'h0, mask_q};
                    fps_pkg::REG_KEY:    avs_readdata_o <= {16'h0, key_got_q, key_exp_q};
                    fps_pkg::REG_TUNE:   avs_readdata_o <= {24'h0, tune_q};
                    default:             avs_readdata_o <= 32'h0;
                endcase
            end
        end
    end
    wire wr_ok = avs_write_i && !avs_waitrequest_o;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl_q    <= 4'h0;
            mask_q    <= 3'h0;
            irq_q     <= 3'h0;
            key_exp_q <= 8'h00;
            start_p   <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                lim_lo_q[i] <= 8'h00;
                lim_hi_q[i] <= 8'hFF;
            end
        end else begin
            start_p <= wr_ok && (widx == fps_pkg::REG_CTRL)
                       && avs_writedata_i[fps_pkg::CTRL_START];
            if (wr_ok && widx == fps_pkg::REG_CTRL)
                ctrl_q <= {avs_writedata_i[3:1], 1'b0};
            if (wr_ok && widx == fps_pkg::REG_MASK) mask_q <= avs_writedata_i[2:0];
            if (wr_ok && widx == fps_pkg::REG_KEY)  key_exp_q <= avs_writedata_i[7:0];
            if (wr_ok && widx == fps_pkg::REG_LIMLO) lim_lo_q[li] <= avs_writedata_i[7:0];
            if (wr_ok && widx == fps_pkg::REG_LIMHI) lim_hi_q[li] <= avs_writedata_i[7:0];
            // set wins over write-one-to-clear
            irq_q <= (irq_q & ~((wr_ok && widx == fps_pkg::REG_IRQ) ? avs_writedata_i[2:0]
                                                                    : 3'h0)) | ev_set;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) irq_o <= 1'b0;
        else         irq_o <= |((irq_q | ev_set) & mask_q);
    end
    // =====================================================================
    // tick and settle timers
    logic tick;
    fps_tick #(.DIV(TICK_DIV)) u_tick (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .run_i  (st_q == S_DSTEP),
        .tick_o (tick)
    );
    logic [15:0] settle_q;
    logic [4:0]  ticks_q;
    logic [4:0]  step_q;
    logic        hi_ok_q;
    wire settled = (settle_q == 16'(SETTLE_DIV));
    function automatic logic [7:0] mux_to_latch(input logic [2:0] m, input logic [4:0] leg);
        mux_to_latch = {leg, m};
    endfunction
    function automatic logic [4:0] step_len(input logic [4:0] s);
        if (s == 5'd0)       step_len = fps_pkg::T_4S;
        else if (s < 5'd11)  step_len = fps_pkg::T_1S;
        else if (s < 5'd21)  step_len = fps_pkg::T_2S;
        else if (s < 5'd27)  step_len = fps_pkg::T_1S;
        else                 step_len = fps_pkg::T_025S;
    endfunction
    // =====================================================================
    // self-test sequencer
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_q <= S_IDLE; test_q <= 3'h0; fail_q <= 1'b0; busy_q <= 1'b0;
            settle_q <= 16'h0; ticks_q <= 5'h0; step_q <= 5'h0; hi_ok_q <= 1'b0;
            key_got_q <= 8'h00; tune_q <= 8'h00; ev_set <= 3'h0;
            bus.addr <= 8'h00; bus.wr <= 1'b0; bus.rd <= 1'b0; bus.wdata <= 8'h00;
            bus.mute <= 1'b0; bus.dac <= 8'h00;
        end else begin
            ev_set   <= 3'h0;
            bus.wr   <= 1'b0;
            bus.rd   <= 1'b0;
            bus.mute <= ctrl_q[fps_pkg::CTRL_MUTE];
            settle_q <= settled ? settle_q : settle_q + 16'h1;
            unique case (st_q)
                S_IDLE: if (start_p) begin
                    busy_q <= 1'b1; fail_q <= 1'b0; st_q <= S_ID;
                end else begin
                    // keep the tuning count fresh while idle
                    bus.addr <= fps_pkg::MA_TUNE; bus.rd <= 1'b1; st_q <= S_TUNE;
                end
                S_TUNE: begin
                    if (bus.rvalid) tune_q <= bus.rdata;
                    if (start_p) begin
                        busy_q <= 1'b1; fail_q <= 1'b0; st_q <= S_ID;
                    end else if (bus.rvalid) st_q <= S_IDLE;
                end
                S_ID: begin
                    bus.addr <= fps_pkg::MA_IDENT; bus.rd <= 1'b1; st_q <= S_IDCHK;
                end
                S_IDCHK: if (bus.rvalid) begin
                    // a panel that does not answer with its ident fails the run
                    fail_q <= fail_q || (bus.rdata != fps_pkg::ASSY_IDENT);
                    test_q <= fps_pkg::MUX_PLUS5_REF; st_q <= S_MUX;
                end
                S_MUX: begin
                    bus.addr  <= fps_pkg::MA_LATCH;
                    bus.wdata <= mux_to_latch(test_q, 5'h00);
                    bus.wr    <= 1'b1;
                    bus.dac   <= (test_q == fps_pkg::MUX_PLUS5_REF) ? fps_pkg::DAC_MAX
                                 : lim_hi_q[test_q[1:0] - 2'h2];
                    settle_q  <= 16'h0; st_q <= S_HI;
                end
                S_HI: if (settled) begin
                    bus.addr <= fps_pkg::MA_CMP; bus.rd <= 1'b1; st_q <= S_HIRD;
                end
                S_HIRD: if (bus.rvalid) begin
                    hi_ok_q <= !bus.rdata[0];
                    if (test_q == fps_pkg::MUX_PLUS5_REF) begin
                        fail_q <= fail_q || bus.rdata[0];
                        st_q   <= S_NEXT;
                    end else begin
                        bus.dac  <= lim_lo_q[test_q[1:0] - 2'h2];
                        settle_q <= 16'h0; st_q <= S_LO;
                    end
                end
                S_LO: if (settled) begin
                    bus.addr <= fps_pkg::MA_CMP; bus.rd <= 1'b1; st_q <= S_LORD;
                end
                S_LORD: if (bus.rvalid) begin
                    fail_q <= fail_q || !hi_ok_q || !bus.rdata[0];
                    st_q   <= S_NEXT;
                end
                S_NEXT: if (test_q == fps_pkg::MUX_LAST_RAIL) begin
                    step_q <= 5'h0; ticks_q <= 5'h0; st_q <= S_DISP;
                end else begin
                    test_q <= test_q + 3'h1; st_q <= S_MUX;
                end
                S_DISP: begin
                    bus.addr  <= (step_q == 5'd0) ? fps_pkg::MA_DISP_DM
                               : (step_q < 5'd11) ? fps_pkg::MA_LATCH
                               : (step_q < 5'd21) ? fps_pkg::MA_DISP_FQ
                               : fps_pkg::MA_DISP_BG;
                    // latch writes keep the multiplexer parked on input 0
                    bus.wdata <= (step_q < 5'd11) ? mux_to_latch(3'h0, step_q)
                               : {step_q[2:0], step_q};
                    bus.wr    <= 1'b1;
                    ticks_q   <= 5'h0; st_q <= S_DSTEP;
                end
                S_DSTEP: if (tick) begin
                    if (ticks_q + 5'h1 == step_len(step_q)) begin
                        if (step_q == 5'd31) st_q <= S_KEYRD;
                        else begin step_q <= step_q + 5'h1; st_q <= S_DISP; end
                    end else ticks_q <= ticks_q + 5'h1;
                end
                S_KEYRD: begin
                    bus.addr <= fps_pkg::MA_SWITCH; bus.rd <= 1'b1; st_q <= S_KEYCHK;
                end
                S_KEYCHK: if (bus.rvalid) begin
                    if (!ctrl_q[fps_pkg::CTRL_KEYCHK]) st_q <= S_DONE;
                    else if (bus.rdata == 8'h00 || bus.rdata[fps_pkg::KEY_MULTI])
                        st_q <= S_KEYRD;
                    else begin
                        key_got_q <= bus.rdata;
                        fail_q    <= fail_q || (bus.rdata != key_exp_q);
                        ev_set[fps_pkg::IRQ_KEY] <= 1'b1; st_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    ev_set[fps_pkg::IRQ_DONE] <= 1'b1;
                    ev_set[fps_pkg::IRQ_FAIL] <= fail_q;
                    if (ctrl_q[fps_pkg::CTRL_CONT]) begin
                        test_q <= fps_pkg::MUX_PLUS5_REF; st_q <= S_MUX;
                    end else begin busy_q <= 1'b0; st_q <= S_IDLE; end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule

// ### sim/fps_bus_sva.sv
// Purpose: concurrent checks on the module bus between processor side and panel
// Assumes: one clock, synchronous active-low reset
// Notes:   instantiated beside the bus interface in the testbench
`timescale 1ns/1ps
module fps_bus_sva (
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic [7:0] addr,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       rvalid,
    input wire logic       cmp
);
    // =====================================================================
    // bus timing and read data
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_rd_answer; rd |=> rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read strobe not answered one cycle later");
    property p_rvalid_cause; rvalid |-> $past(rd); endproperty
    a_rvalid_cause: assert property (p_rvalid_cause)
        else $error("read valid without a read strobe");
    property p_rd_single; rd |=> !rd; endproperty
    a_rd_single: assert property (p_rd_single)
        else $error("read strobe longer than one cycle");
    property p_rvalid_pulse; rvalid |=> !rvalid; endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse)
        else $error("read valid longer than one cycle");
    property p_ident; rd && addr == fps_pkg::MA_IDENT |=> rdata == fps_pkg::ASSY_IDENT; endproperty
    a_ident: assert property (p_ident)
        else $error("assembly ident read returned a wrong code");
    property p_cmp_bit; rd && addr == fps_pkg::MA_CMP |=> rvalid && rdata[7:1] == 7'h00; endproperty
    a_cmp_bit: assert property (p_cmp_bit)
        else $error("comparator read is not a single bit");
    property p_cmp_match;
        rvalid && $past(addr) == fps_pkg::MA_CMP |-> rdata[0] == cmp;
    endproperty
    a_cmp_match: assert property (p_cmp_match)
        else $error("comparator read bit differs from comparator line");
    property p_no_both; !(wr && rd); endproperty
    a_no_both: assert property (p_no_both)
        else $error("read and write strobes together");
    property p_mux_range;
        wr && addr == fps_pkg::MA_LATCH |-> wdata[2:0] <= fps_pkg::MUX_LAST_RAIL;
    endproperty
    a_mux_range: assert property (p_mux_range)
        else $error("latch written with a multiplexer input out of range");
endmodule

// ### sim/testbench.sv
// Purpose: drives the processor side over avalon and the panel pins, checks results
// Assumes: fps_proc and fps_panel joined through fps_bus_if
// Notes:   short tick and settle dividers keep the self-test run brief
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [5:0]  avs_address_i = 6'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        irq_o;
    logic [7:0]  tune_count_i = 8'h3C;
    logic [7:0]  switch_code_i = 8'h00;
    logic [7:0]  level_i = 8'h80;
    logic        mute_o;
    logic [2:0]  mux_sel_o;
    logic        wr_dm_o;
    logic        wr_fq_o;
    logic        wr_bg_o;
    int          n_dm = 0;
    int          n_fq = 0;
    int          n_bg = 0;
    int          n_mismatch = 0;
    int          tests_run = 0;
    logic [31:0] rv;
    always #50 clk_i = ~clk_i;
    // display write strobes are one-cycle pulses
    always @(posedge clk_i) begin
        if (wr_dm_o === 1'b1) n_dm <= n_dm + 1;
        if (wr_fq_o === 1'b1) n_fq <= n_fq + 1;
        if (wr_bg_o === 1'b1) n_bg <= n_bg + 1;
    end
    fps_bus_if fps_bus_if_i (.clk_i(clk_i));
    fps_proc #(.TICK_DIV(4), .SETTLE_DIV(4)) fps_proc_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .bus(fps_bus_if_i.proc),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
    fps_panel fps_panel_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .bus(fps_bus_if_i.panel),
        .tune_count_i(tune_count_i), .switch_code_i(switch_code_i), .level_i(level_i),
        .mute_o(mute_o), .mux_sel_o(mux_sel_o), .legends_o(), .wr_dm_o(wr_dm_o),
        .wr_fq_o(wr_fq_o), .wr_bg_o(wr_bg_o), .disp_data_o());
    fps_bus_sva fps_bus_sva_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr(fps_bus_if_i.addr), .wr(fps_bus_if_i.wr),
        .rd(fps_bus_if_i.rd), .wdata(fps_bus_if_i.wdata), .rdata(fps_bus_if_i.rdata),
        .rvalid(fps_bus_if_i.rvalid), .cmp(fps_bus_if_i.cmp));
    // =====================================================================
    // shared tasks
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until waitrequest is sampled low, released after that edge
    task automatic av(input logic w, input logic [3:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address_i <= {idx, 2'b00};
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= wd;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 100) begin
            n_mismatch++;
            complete_run();
        end
        rv = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic poll(input logic [3:0] idx, input int bitn, input int tries);
        int n;
        n = 0;
        rv = 32'h0;
        while (rv[bitn] !== 1'b1 && n < tries) begin
            av(1'b0, idx, 32'h0);
            n++;
        end
        if (rv[bitn] !== 1'b1) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    // =====================================================================
    // scenarios
    task automatic t_mute();
        av(1'b1, fps_pkg::REG_CTRL, 32'h1 << fps_pkg::CTRL_MUTE);
        repeat (4) @(posedge clk_i);
        chk("mute on", 32'h1, {31'h0, mute_o});
        av(1'b1, fps_pkg::REG_CTRL, 32'h0);
        repeat (4) @(posedge clk_i);
        chk("mute off", 32'h0, {31'h0, mute_o});
    endtask
    task automatic t_unmapped();
        av(1'b1, 4'hE, 32'hA5A5_A5A5);
        av(1'b0, 4'hE, 32'h0);
        chk("unmapped read", 32'h0, rv);
    endtask
    task automatic t_tune();
        int n;
        n = 0;
        rv = 32'h0;
        while (rv[7:0] !== tune_count_i && n < 50) begin
            av(1'b0, fps_pkg::REG_TUNE, 32'h0);
            n++;
        end
        chk("tuning count", {24'h0, tune_count_i}, {24'h0, rv[7:0]});
    endtask
    task automatic t_run_pass();
        int dm0, fq0, bg0;
        dm0 = n_dm;
        fq0 = n_fq;
        bg0 = n_bg;
        av(1'b1, fps_pkg::REG_MASK, 32'h0);
        av(1'b1, fps_pkg::REG_CTRL, 32'h1 << fps_pkg::CTRL_START);
        poll(fps_pkg::REG_IRQ, fps_pkg::IRQ_DONE, 8000);
        chk("message writes", 32'h1, 32'(n_dm - dm0));
        chk("digit writes", 32'hA, 32'(n_fq - fq0));
        chk("bargraph writes", 32'hB, 32'(n_bg - bg0));
        chk("mux parked", 32'h0, {29'h0, mux_sel_o});
        chk("irq masked", 32'h0, {31'h0, irq_o});
        av(1'b1, fps_pkg::REG_MASK, 32'h1 << fps_pkg::IRQ_DONE);
        repeat (2) @(posedge clk_i);
        chk("irq unmasked", 32'h1, {31'h0, irq_o});
        av(1'b1, fps_pkg::REG_IRQ, 32'h7);
        av(1'b0, fps_pkg::REG_IRQ, 32'h0);
        chk("irq cleared", 32'h0, {29'h0, rv[2:0]});
        chk("irq line low", 32'h0, {31'h0, irq_o});
    endtask
    task automatic t_run_fail();
        level_i <= 8'hFF;
        av(1'b1, fps_pkg::REG_CTRL, 32'h1 << fps_pkg::CTRL_START);
        poll(fps_pkg::REG_IRQ, fps_pkg::IRQ_FAIL, 8000);
        av(1'b0, fps_pkg::REG_STATUS, 32'h0);
        chk("status fail", 32'h1, {31'h0, rv[6]});
        av(1'b1, fps_pkg::REG_IRQ, 32'h7);
    endtask
    // =====================================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        chk("waitrequest idle", 32'h1, {31'h0, avs_waitrequest_o});
        chk("irq after reset", 32'h0, {31'h0, irq_o});
        chk("mute after reset", 32'h0, {31'h0, mute_o});
        t_mute();
        t_unmapped();
        t_tune();
        t_run_pass();
        t_run_fail();
        complete_run();
    end
endmodule
